// ===== hw/fpeu_params.svh
// Constants for the flash program/erase unlock block: register offsets,
// field positions, reset values, key bytes and flash geometry.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FPEU_PARAMS_SVH
`define FPEU_PARAMS_SVH

// Special function register offsets
`define FPEU_ADDR_PSC        8'h8f
`define FPEU_ADDR_KEY        8'hb7

// Bus widths
`define FPEU_SFR_AW          8
`define FPEU_DW              8
`define FPEU_XAW             16

// Program-store control field positions
`define FPEU_PSC_WE_BIT      0
`define FPEU_PSC_EE_BIT      1

// Reset values
`define FPEU_PSC_RESET       8'h00
`define FPEU_KEY_RESET       8'h00

// Key sequence bytes
`define FPEU_KEY_FIRST       8'ha5
`define FPEU_KEY_SECOND      8'hf1

// Flash page size as address bits (512-byte pages)
`define FPEU_PAGE_BITS       9

// Data value sent to the flash array during an erase
`define FPEU_ERASE_DATA      8'h00

`endif

// ===== hw/fpeu_pkg.sv
// Types shared by the flash program/erase unlock design files.
// Assumes the constants header is on the include path.
`include "fpeu_params.svh"

package fpeu_pkg;

  // Lock-state code, read back in the low two key-register bits
  typedef enum logic [1:0] {
    FPEU_LOCKED   = 2'b00,
    FPEU_KEY1     = 2'b01,
    FPEU_UNLOCKED = 2'b10,
    FPEU_LOCKOUT  = 2'b11
  } fpeu_lock_t;

  typedef logic [`FPEU_SFR_AW-1:0] fpeu_sfr_addr_t;
  typedef logic [`FPEU_DW-1:0]     fpeu_byte_t;
  typedef logic [`FPEU_XAW-1:0]    fpeu_xaddr_t;

  // State of the external-move router
  typedef struct packed {
    logic        xram_wr;
    fpeu_xaddr_t xram_addr;
    fpeu_byte_t  xram_wdata;
    logic        flash_prog;
    logic        flash_erase;
    fpeu_xaddr_t flash_addr;
    fpeu_byte_t  flash_wdata;
  } fpeu_route_t;

  // State of the top-level sequencer and register file
  typedef struct packed {
    logic       page_erase_enable;
    logic       flash_write_enable;
    fpeu_lock_t lock;
    logic       lockout;
    logic       busy;
    fpeu_byte_t sfr_rdata;
  } fpeu_state_t;

endpackage

// ===== hw/fpeu_route.sv
// External-move write router: steers a write to external data memory when flash
// writes are disabled, or, when flash writes are enabled and the write is granted, to a flash byte program or page erase; an ungranted write is dropped.
// Assumes the sequencer supplies a one-cycle grant for permitted flash operations.
`timescale 1ns/1ns
`include "fpeu_params.svh"

module fpeu_route (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          xmove_wr,
  input  fpeu_pkg::fpeu_xaddr_t xmove_addr,
  input  fpeu_pkg::fpeu_byte_t  xmove_wdata,
  input  wire logic          flash_write_enable,
  input  wire logic          page_erase_enable,
  input  wire logic          grant,
  output logic               xram_wr,
  output fpeu_pkg::fpeu_xaddr_t xram_addr,
  output fpeu_pkg::fpeu_byte_t  xram_wdata,
  output logic               flash_prog,
  output logic               flash_erase,
  output fpeu_pkg::fpeu_xaddr_t flash_addr,
  output fpeu_pkg::fpeu_byte_t  flash_wdata
);
  import fpeu_pkg::*;

  fpeu_route_t r;
  fpeu_route_t next_r;

  // Page base of an address, used for erase requests
  function automatic fpeu_xaddr_t page_base(input fpeu_xaddr_t a);
    page_base = {a[`FPEU_XAW-1:`FPEU_PAGE_BITS], {`FPEU_PAGE_BITS{1'b0}}};
  endfunction

  // Next-state routing of one external-move write
  always_comb begin
    next_r             = r;
    next_r.xram_wr     = xmove_wr & ~flash_write_enable;
    next_r.flash_prog  = grant & ~page_erase_enable;
    next_r.flash_erase = grant & page_erase_enable;
    if (xmove_wr && !flash_write_enable) begin
      next_r.xram_addr  = xmove_addr;
      next_r.xram_wdata = xmove_wdata;
    end
    if (grant && !page_erase_enable) begin
      next_r.flash_addr  = xmove_addr;
      next_r.flash_wdata = xmove_wdata;
    end
    if (grant && page_erase_enable) begin
      next_r.flash_addr  = page_base(xmove_addr);
      next_r.flash_wdata = `FPEU_ERASE_DATA;                   // Data byte dropped
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops
  assign xram_wr     = r.xram_wr;
  assign xram_addr   = r.xram_addr;
  assign xram_wdata  = r.xram_wdata;
  assign flash_prog  = r.flash_prog;
  assign flash_erase = r.flash_erase;
  assign flash_addr  = r.flash_addr;
  assign flash_wdata = r.flash_wdata;

endmodule

// ===== hw/fpeu_top.sv
// Flash program/erase unlock block: program-store control register, key
// register with its lock sequencer, and the external-move router.
// Assumes a CPU register port with one-cycle read/write strobes, and a flash
// array that pulses flash_done once each program or erase has finished.
//
// Contract
// - Control register bits 7:2 read zero; writes to them are ignored.
// - Write enable set, erase clear: external-move write programs one flash byte at address.
// - Write enable clear: external-move writes never modify flash.
// - Erase and write enable set: external-move write erases the addressed page.
// - The data byte of an erasing write is ignored.
// - Flash operations allowed only after key bytes a5 then f1.
// - Lock returns automatically when the unlocked operation completes.
// - Any wrong key write locks flash out until reset.
// - Flash operation attempted while not unlocked also locks out until reset.
// - Key read low bits: 00 locked, 01 first key accepted.
// - Key read low bits: 10 unlocked, 11 locked out until reset.
`timescale 1ns/1ns
`include "fpeu_params.svh"

module fpeu_top (
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Special function register port
  input  fpeu_pkg::fpeu_sfr_addr_t sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  fpeu_pkg::fpeu_byte_t   sfr_wdata,
  output fpeu_pkg::fpeu_byte_t   sfr_rdata,
  // External-move write from the core
  input  wire logic              xmove_wr,
  input  fpeu_pkg::fpeu_xaddr_t  xmove_addr,
  input  fpeu_pkg::fpeu_byte_t   xmove_wdata,
  // Flash array completion
  input  wire logic              flash_done,
  // External data memory side
  output logic                   xram_wr,
  output fpeu_pkg::fpeu_xaddr_t  xram_addr,
  output fpeu_pkg::fpeu_byte_t   xram_wdata,
  // Flash array side
  output logic                   flash_prog,
  output logic                   flash_erase,
  output fpeu_pkg::fpeu_xaddr_t  flash_addr,
  output fpeu_pkg::fpeu_byte_t   flash_wdata,
  // Core stall while a flash operation runs
  output logic                   cpu_stall,
  // Lockout status
  output logic                   lockout_active
);
  import fpeu_pkg::*;

  fpeu_state_t s;
  fpeu_state_t next_s;

  // Control register reset value, kept as a byte so single bits can be picked
  localparam fpeu_byte_t psc_reset_val = `FPEU_PSC_RESET;

  logic psc_wr;
  logic key_wr;
  logic psc_rd;
  logic key_rd;
  logic flash_attempt;
  logic grant;

  // Register decode
  function automatic logic hit(input fpeu_sfr_addr_t a, input fpeu_sfr_addr_t reg_addr);
    hit = (a == reg_addr);
  endfunction

  // One step of the key sequencer for a key-register write
  function automatic fpeu_lock_t key_step(input fpeu_lock_t cur, input fpeu_byte_t val);
    case (cur)
      FPEU_LOCKED: begin
        if (val == `FPEU_KEY_FIRST) begin
          key_step = FPEU_KEY1;
        end else begin
          key_step = FPEU_LOCKOUT;
        end
      end
      FPEU_KEY1: begin
        if (val == `FPEU_KEY_SECOND) begin
          key_step = FPEU_UNLOCKED;
        end else begin
          key_step = FPEU_LOCKOUT;
        end
      end
      FPEU_UNLOCKED: begin
        key_step = FPEU_LOCKOUT;                 // Extra key write breaks sequence
      end
      FPEU_LOCKOUT: begin
        key_step = FPEU_LOCKOUT;                 // Held until reset
      end
      default: begin
        key_step = FPEU_LOCKOUT;
      end
    endcase
  endfunction

  // Read value of the program-store control register
  function automatic fpeu_byte_t psc_read(input logic ee, input logic we);
    fpeu_byte_t v;
    v = '0;                                      // Upper bits read zero
    v[`FPEU_PSC_EE_BIT] = ee;
    v[`FPEU_PSC_WE_BIT] = we;
    psc_read = v;
  endfunction

  // Read value of the key register: lock code in the low two bits
  function automatic fpeu_byte_t key_read(input fpeu_lock_t l);
    key_read = {6'h00, l};
  endfunction

  // Strobe decode
  assign psc_wr = sfr_wr & hit(sfr_addr, `FPEU_ADDR_PSC);
  assign key_wr = sfr_wr & hit(sfr_addr, `FPEU_ADDR_KEY);
  assign psc_rd = sfr_rd & hit(sfr_addr, `FPEU_ADDR_PSC);
  assign key_rd = sfr_rd & hit(sfr_addr, `FPEU_ADDR_KEY);

  // Flash operation request and permission
  assign flash_attempt = xmove_wr & s.flash_write_enable & ~s.busy;
  assign grant         = flash_attempt & (s.lock == FPEU_UNLOCKED);

  // Next-state logic for control bits, sequencer, busy flag and read data
  always_comb begin
    next_s = s;

    // Control register write: only the two low bits are stored
    if (psc_wr) begin
      next_s.flash_write_enable = sfr_wdata[`FPEU_PSC_WE_BIT];
      next_s.page_erase_enable  = sfr_wdata[`FPEU_PSC_EE_BIT];
    end

    // Key register writes advance or break the sequence
    if (key_wr) begin
      next_s.lock = key_step(s.lock, sfr_wdata);
    end

    // Operation attempted while not unlocked forces lockout
    if (flash_attempt && s.lock != FPEU_UNLOCKED) begin
      next_s.lock = FPEU_LOCKOUT;
    end

    // Start of a permitted operation
    if (grant) begin
      next_s.busy = 1'b1;
    end

    // Completion relocks; a concurrent lockout still wins
    if (s.busy && flash_done) begin
      next_s.busy = 1'b0;
      if (next_s.lock == FPEU_UNLOCKED) begin
        next_s.lock = FPEU_LOCKED;
      end
    end

    // Lockout status flop tracks the lock code so the output leaves a flop
    next_s.lockout = (next_s.lock == FPEU_LOCKOUT);

    // Registered read data; unmapped or idle reads give zero
    if (psc_rd) begin
      next_s.sfr_rdata = psc_read(s.page_erase_enable, s.flash_write_enable);
    end else if (key_rd) begin
      next_s.sfr_rdata = key_read(s.lock);
    end else begin
      next_s.sfr_rdata = '0;
    end
  end

  // State register; reset returns everything to locked
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s.page_erase_enable  <= psc_reset_val[`FPEU_PSC_EE_BIT];
      s.flash_write_enable <= psc_reset_val[`FPEU_PSC_WE_BIT];
      s.lock               <= FPEU_LOCKED;
      s.lockout            <= 1'b0;
      s.busy               <= 1'b0;
      s.sfr_rdata          <= `FPEU_KEY_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Register outputs
  assign sfr_rdata      = s.sfr_rdata;
  assign cpu_stall      = s.busy;
  assign lockout_active = s.lockout;

  // Router for external-move writes
  fpeu_route u_route (
    .clk                (clk),
    .rst_b              (rst_b),
    .xmove_wr           (xmove_wr),
    .xmove_addr         (xmove_addr),
    .xmove_wdata        (xmove_wdata),
    .flash_write_enable (s.flash_write_enable),
    .page_erase_enable  (s.page_erase_enable),
    .grant              (grant),
    .xram_wr            (xram_wr),
    .xram_addr          (xram_addr),
    .xram_wdata         (xram_wdata),
    .flash_prog         (flash_prog),
    .flash_erase        (flash_erase),
    .flash_addr         (flash_addr),
    .flash_wdata        (flash_wdata)
  );

endmodule

// ===== tb/fpeu_top_sva.sv
// Concurrent checks on the ports of the flash unlock block.
// Assumes it is bound to fpeu_top and sees its ports only.
`timescale 1ns/1ns
module fpeu_top_sva (
  input wire logic                clk,
  input wire logic                rst_b,
  input fpeu_pkg::fpeu_sfr_addr_t sfr_addr,
  input wire logic                sfr_wr,
  input wire logic                sfr_rd,
  input fpeu_pkg::fpeu_byte_t     sfr_wdata,
  input fpeu_pkg::fpeu_byte_t     sfr_rdata,
  input wire logic                xmove_wr,
  input fpeu_pkg::fpeu_xaddr_t    xmove_addr,
  input fpeu_pkg::fpeu_byte_t     xmove_wdata,
  input wire logic                flash_done,
  input wire logic                xram_wr,
  input fpeu_pkg::fpeu_xaddr_t    xram_addr,
  input fpeu_pkg::fpeu_byte_t     xram_wdata,
  input wire logic                flash_prog,
  input wire logic                flash_erase,
  input fpeu_pkg::fpeu_xaddr_t    flash_addr,
  input fpeu_pkg::fpeu_byte_t     flash_wdata,
  input wire logic                cpu_stall,
  input wire logic                lockout_active
);
  import fpeu_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_ctl_upper_zero: assert property (sfr_rd && sfr_addr == 8'h8f |=> sfr_rdata[7:2] == 6'h00)
    else $error("control upper bits not zero");
  a_prog_copy: assert property (flash_prog |-> $past(xmove_wr)
    && flash_addr == $past(xmove_addr) && flash_wdata == $past(xmove_wdata))
    else $error("program strobe does not carry the move");
  a_move_exclusive: assert property (xram_wr |-> !flash_prog && !flash_erase)
    else $error("move went to both targets");
  a_erase_page: assert property (flash_erase |-> flash_wdata == 8'h00
    && flash_addr == {$past(xmove_addr[15:9]), 9'h000})
    else $error("erase address or data wrong");
  a_single_op: assert property ((flash_prog || flash_erase) |=> (!flash_prog && !flash_erase)[*4])
    else $error("second flash operation without a new key");
  a_stall_release: assert property (cpu_stall && flash_done |=> !cpu_stall)
    else $error("stall held after completion");
  a_lockout_holds: assert property (lockout_active |=> lockout_active)
    else $error("lockout left without reset");
  a_lockout_blocks: assert property (lockout_active |-> ##1 !flash_prog && !flash_erase)
    else $error("flash operation during lockout");
  a_lock_code: assert property (sfr_rd && sfr_addr == 8'hb7
    |=> (sfr_rdata[1:0] == 2'b11) == $past(lockout_active))
    else $error("lock code disagrees with lockout");
  a_xram_path: assert property (xram_wr |-> $past(xmove_wr) && xram_addr == $past(xmove_addr)
    && xram_wdata == $past(xmove_wdata))
    else $error("external memory write does not carry the move");
endmodule

// ===== tb/fpeu_flash_model.sv
// Flash array stand-in: answers each program or erase strobe with a done pulse.
// Assumes strobes arrive one at a time from the block under test.
`timescale 1ns/1ns
module fpeu_flash_model #(
  parameter int DLY = 6
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic flash_prog,
  input  wire logic flash_erase,
  output logic      flash_done
);
  int cnt;
  // Count down from the strobe, then pulse done for one cycle
  always @(posedge clk) begin
    flash_done <= 1'b0;
    if (!rst_b) begin
      cnt <= 0;
    end else if (flash_prog || flash_erase) begin
      cnt <= DLY;
    end else if (cnt == 1) begin
      cnt <= 0;
      flash_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the flash unlock block with a flash array stand-in.
// Assumes the register and move timing of the block's hand-over contract.
`timescale 1ns/1ns
module tb_top;
  import fpeu_pkg::*;
  logic           clk         = 1'b0;
  logic           rst_b       = 1'b0;
  fpeu_sfr_addr_t sfr_addr    = 8'h00;
  logic           sfr_wr      = 1'b0;
  logic           sfr_rd      = 1'b0;
  fpeu_byte_t     sfr_wdata   = 8'h00;
  logic           xmove_wr    = 1'b0;
  fpeu_xaddr_t    xmove_addr  = 16'h0000;
  fpeu_byte_t     xmove_wdata = 8'h00;
  fpeu_byte_t     sfr_rdata, xram_wdata, flash_wdata, last_fd;
  fpeu_xaddr_t    xram_addr, flash_addr, last_fa;
  logic           flash_done, xram_wr, flash_prog, flash_erase, cpu_stall, lockout_active;
  int             errors = 0;
  int             n_tests = 0;
  int             cyc = 0;
  int             n_prog = 0;
  int             n_erase = 0;
  int             n_xram = 0;
  int             n_stall = 0;

  fpeu_top u_fpeu_top (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xmove_wr(xmove_wr),
    .xmove_addr(xmove_addr), .xmove_wdata(xmove_wdata), .flash_done(flash_done),
    .xram_wr(xram_wr), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .cpu_stall(cpu_stall), .lockout_active(lockout_active));
  fpeu_flash_model u_fpeu_flash_model (.clk(clk), .rst_b(rst_b), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_done(flash_done));

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      complete_run();
    end
  end
  // Count strobes where outputs have settled
  always @(negedge clk) begin
    if (xram_wr === 1'b1) n_xram++;
    if (cpu_stall === 1'b1) n_stall++;
    if (flash_prog === 1'b1 || flash_erase === 1'b1) begin
      if (flash_prog === 1'b1) n_prog++;
      if (flash_erase === 1'b1) n_erase++;
      last_fa = flash_addr;
      last_fd = flash_wdata;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input fpeu_sfr_addr_t a, input fpeu_byte_t d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  // Read, then compare the lock code or the whole byte
  task automatic rdc(input fpeu_sfr_addr_t a, input fpeu_byte_t exp, input string name);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    if (a == 8'hb7) check(name, {14'h0, sfr_rdata[1:0]}, {8'h00, exp});
    else check(name, {8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic xmv(input fpeu_xaddr_t a, input fpeu_byte_t d);
    @(posedge clk);
    xmove_wr <= 1'b1;
    xmove_addr <= a;
    xmove_wdata <= d;
    @(posedge clk);
    xmove_wr <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 30 && cpu_stall !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic key();
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'hf1);
  endtask
  task automatic rst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h8f, 8'h00, "ctl");
    rdc(8'hb7, 8'h00, "lock");
    wr(8'h8f, 8'hff);
    rdc(8'h8f, 8'h03, "ctl");
    wr(8'h90, 8'hff);
    rdc(8'h90, 8'h00, "unmapped");
    wr(8'h8f, 8'h02);
    xmv(16'h0042, 8'h77);
    check("xram", 16'(n_xram), 16'd1);
    check("xram_addr", xram_addr, 16'h0042);
    check("xram_data", {8'h00, xram_wdata}, 16'h0077);
    check("flash", 16'(n_prog + n_erase), 16'd0);
    wr(8'hb7, 8'ha5);
    rdc(8'hb7, 8'h01, "lock");
    wr(8'hb7, 8'hf1);
    rdc(8'hb7, 8'h02, "lock");
    wr(8'h8f, 8'h03);
    xmv(16'h1234, 8'h5a);
    check("erase", 16'(n_erase), 16'd1);
    check("erase_addr", last_fa, 16'h1200);
    check("erase_data", {8'h00, last_fd}, 16'h0000);
    // Stall spans the strobe cycle, the model's 6-cycle delay and the done cycle
    check("stall", 16'(n_stall), 16'd8);
    rdc(8'hb7, 8'h00, "lock");
    key();
    wr(8'h8f, 8'h01);
    xmv(16'h1234, 8'h3c);
    check("prog", 16'(n_prog), 16'd1);
    check("prog_addr", last_fa, 16'h1234);
    check("prog_data", {8'h00, last_fd}, 16'h003c);
    rdc(8'hb7, 8'h00, "lock");
    xmv(16'h1300, 8'h11);
    check("prog", 16'(n_prog), 16'd1);
    rdc(8'hb7, 8'h03, "lock");
    key();
    rdc(8'hb7, 8'h03, "lock");
    check("lockout", {15'h0, lockout_active}, 16'h0001);
    rst();
    rdc(8'hb7, 8'h00, "lock");
    rdc(8'h8f, 8'h00, "ctl");
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'h00);
    rdc(8'hb7, 8'h03, "lock");
    rst();
    wr(8'hb7, 8'h5a);
    rdc(8'hb7, 8'h03, "lock");
    rst();
    key();
    wr(8'hb7, 8'ha5);
    rdc(8'hb7, 8'h03, "lock");
    complete_run();
  end
endmodule

bind fpeu_top fpeu_top_sva u_fpeu_top_sva (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .xmove_wr(xmove_wr), .xmove_addr(xmove_addr), .xmove_wdata(xmove_wdata),
  .flash_done(flash_done), .xram_wr(xram_wr), .xram_addr(xram_addr),
  .xram_wdata(xram_wdata), .flash_prog(flash_prog), .flash_erase(flash_erase),
  .flash_addr(flash_addr), .flash_wdata(flash_wdata), .cpu_stall(cpu_stall),
  .lockout_active(lockout_active));
